// ==== qcu_top.sv ====
// channel unit symbol interface: parallel and serial quaternary symbol exchange
`include "qcu_params.svh"
`default_nettype none

module qcu_top #(
  parameter int SYM_CYCLES = `QCU_SYM_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // channel unit pins
  output logic symbol_clock,
  output logic rx_sign_out,
  output logic rx_magnitude_out,
  input wire logic tx_sign_in,
  input wire logic tx_magnitude_in,
  input wire logic tx_baud_clock_in,
  input wire logic rx_baud_clock_in,
  // receiver and transmitter side
  input wire qcu_pkg::qcu_sym_t rx_sym_in,
  output qcu_pkg::qcu_sym_t tx_sym,
  output logic tx_sym_valid
);

  // ----------------------------------------------------------------
  // clocks and pin synchronisers
  // ----------------------------------------------------------------
  logic bit_clock;
  logic ev_sym_rise;
  logic ev_sym_fall;
  logic ev_bit_fall_a;
  logic ev_bit_fall_b;
  logic [3:0] pins_s;
  logic tx_sign_s;
  logic tx_mag_s;
  logic txb_s;
  logic rxb_s;

  qcu_clkgen #(.SYM_CYCLES(SYM_CYCLES)) u_clkgen (
    .clk_sys(clk_sys),
    .rst(rst),
    .symbol_clock(symbol_clock),
    .bit_clock(bit_clock),
    .ev_sym_rise(ev_sym_rise),
    .ev_sym_fall(ev_sym_fall),
    .ev_bit_fall_a(ev_bit_fall_a),
    .ev_bit_fall_b(ev_bit_fall_b)
  );

  qcu_sync #(.W(4)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d({tx_sign_in, tx_magnitude_in, tx_baud_clock_in, rx_baud_clock_in}),
    .q(pins_s)
  );

  assign tx_sign_s = pins_s[3];
  assign tx_mag_s = pins_s[2];
  assign txb_s = pins_s[1];
  assign rxb_s = pins_s[0];

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  logic [7:0] mode_reg;
  logic [7:0] next_mode_reg;
  logic [7:0] next_rdata;
  logic [7:0] status;
  qcu_pkg::qcu_mode_t cu_mode;
  logic rx_edge_fall;
  logic tx_edge_fall;

  function automatic logic is_serial(input qcu_pkg::qcu_mode_t m);
    is_serial = (m == qcu_pkg::QCU_SER_MAG_FIRST) || (m == qcu_pkg::QCU_SER_SIGN_FIRST);
  endfunction

  assign cu_mode = qcu_pkg::qcu_mode_t'(mode_reg[`QCU_FLD_MODE_LSB +: 2]);
  assign rx_edge_fall = mode_reg[`QCU_FLD_RXEDGE];
  assign tx_edge_fall = mode_reg[`QCU_FLD_TXEDGE];

  always_comb begin
    next_mode_reg = mode_reg;
    if (wr && (addr == `QCU_ADDR_MODE)) begin
      next_mode_reg = wdata;
    end
    next_rdata = 8'h00;
    if (rd) begin
      if (addr == `QCU_ADDR_MODE) begin
        next_rdata = mode_reg;
      end else if (addr == `QCU_ADDR_STATUS) begin
        next_rdata = status;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_reg <= `QCU_MODE_RESET;
      rdata <= 8'h00;
    end else begin
      mode_reg <= next_mode_reg;
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // event alignment
  // ----------------------------------------------------------------
  // own strobes are delayed by the synchroniser depth so that they
  // meet the pin value that stood at the clock edge itself
  logic [2:0] ev_d1;
  logic [2:0] ev_d2;
  logic [2:0] next_ev_d1;
  logic [2:0] next_ev_d2;
  logic [1:0] baud_h;
  logic [1:0] next_baud_h;
  logic rxb_ev;
  logic txb_ev;

  assign rxb_ev = rx_edge_fall ? (baud_h[0] && !rxb_s) : (!baud_h[0] && rxb_s);
  assign txb_ev = tx_edge_fall ? (baud_h[1] && !txb_s) : (!baud_h[1] && txb_s);

  always_comb begin
    next_ev_d1 = {ev_bit_fall_b, ev_bit_fall_a, ev_sym_fall};
    next_ev_d2 = ev_d1;
    next_baud_h = {txb_s, rxb_s};
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ev_d1 <= 3'h0;
      ev_d2 <= 3'h0;
      baud_h <= 2'h0;
    end else begin
      ev_d1 <= next_ev_d1;
      ev_d2 <= next_ev_d2;
      baud_h <= next_baud_h;
    end
  end

  // ----------------------------------------------------------------
  // symbol datapath
  // ----------------------------------------------------------------
  logic rx_sign_q;
  logic rx_mag_q;
  logic rx_second;
  logic rx_pending;
  logic tx_first;
  logic next_rx_sign_q;
  logic next_rx_mag_q;
  logic next_rx_second;
  logic next_rx_pending;
  logic next_tx_first;
  qcu_pkg::qcu_sym_t next_tx_sym;
  logic next_tx_sym_valid;
  logic mag_first;

  assign mag_first = cu_mode == qcu_pkg::QCU_SER_MAG_FIRST;

  always_comb begin
    next_rx_sign_q = rx_sign_q;
    next_rx_mag_q = rx_mag_q;
    next_rx_second = rx_second;
    next_rx_pending = rx_pending;
    next_tx_first = tx_first;
    next_tx_sym = tx_sym;
    next_tx_sym_valid = 1'b0;
    unique case (cu_mode)
      qcu_pkg::QCU_PAR_MASTER: begin
        next_rx_pending = 1'b0;
        if (ev_sym_rise) begin
          next_rx_sign_q = rx_sym_in.sign;
          next_rx_mag_q = rx_sym_in.mag;
        end
        if (ev_d2[0]) begin
          next_tx_sym = '{sign: tx_sign_s, mag: tx_mag_s};
          next_tx_sym_valid = 1'b1;
        end
      end
      qcu_pkg::QCU_PAR_SLAVE: begin
        next_rx_pending = 1'b0;
        if (rxb_ev) begin
          next_rx_sign_q = rx_sym_in.sign;
          next_rx_mag_q = rx_sym_in.mag;
        end
        if (txb_ev) begin
          next_tx_sym = '{sign: tx_sign_s, mag: tx_mag_s};
          next_tx_sym_valid = 1'b1;
        end
      end
      qcu_pkg::QCU_SER_MAG_FIRST, qcu_pkg::QCU_SER_SIGN_FIRST: begin
        if (ev_sym_rise) begin
          next_rx_sign_q = mag_first ? rx_sym_in.mag : rx_sym_in.sign;
          next_rx_second = mag_first ? rx_sym_in.sign : rx_sym_in.mag;
          next_rx_pending = 1'b1;
        end else if (ev_sym_fall) begin
          next_rx_sign_q = rx_second;
          next_rx_pending = 1'b0;
        end
        if (ev_d2[1]) begin
          next_tx_first = tx_sign_s;
        end
        if (ev_d2[2]) begin
          // tx_mag_s is not looked at here
          next_tx_sym.sign = mag_first ? tx_sign_s : tx_first;
          next_tx_sym.mag = mag_first ? tx_first : tx_sign_s;
          next_tx_sym_valid = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_sign_q <= 1'b0;
      rx_mag_q <= 1'b0;
      rx_second <= 1'b0;
      rx_pending <= 1'b0;
      tx_first <= 1'b0;
      tx_sym <= '0;
      tx_sym_valid <= 1'b0;
    end else begin
      rx_sign_q <= next_rx_sign_q;
      rx_mag_q <= next_rx_mag_q;
      rx_second <= next_rx_second;
      rx_pending <= next_rx_pending;
      tx_first <= next_tx_first;
      tx_sym <= next_tx_sym;
      tx_sym_valid <= next_tx_sym_valid;
    end
  end

  // ----------------------------------------------------------------
  // pin multiplexing and status
  // ----------------------------------------------------------------
  // in serial modes the sign pin carries serial data and the magnitude pin the bit clock
  assign rx_sign_out = rx_sign_q;
  assign rx_magnitude_out = is_serial(cu_mode) ? bit_clock : rx_mag_q;
  assign status = {3'h0, rxb_s, txb_s, rx_pending, tx_sym.sign, tx_sym.mag};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_mode_write_takes: assert property (
    wr && (addr == `QCU_ADDR_MODE) |=> cu_mode == qcu_pkg::qcu_mode_t'($past(wdata[1:0])))
    else $error("mode register write not applied");

  a_master_rx_update: assert property (
    (cu_mode == qcu_pkg::QCU_PAR_MASTER) && ev_sym_rise && $stable(mode_reg)
    |=> $rose(symbol_clock) && (rx_sign_out == $past(rx_sym_in.sign)) && (rx_magnitude_out == $past(rx_sym_in.mag)))
    else $error("parallel master receive bits not updated at symbol clock rise");

  a_master_rx_hold: assert property (
    (cu_mode == qcu_pkg::QCU_PAR_MASTER) && !ev_sym_rise && $stable(mode_reg)
    |=> $stable({rx_sign_out, rx_magnitude_out}))
    else $error("parallel receive bits changed between symbols");

  a_slave_rx_edge: assert property (
    (cu_mode == qcu_pkg::QCU_PAR_SLAVE) && rxb_ev && $stable(mode_reg) && !wr
    |=> (rx_sign_out == $past(rx_sym_in.sign)) && (rx_magnitude_out == $past(rx_sym_in.mag)))
    else $error("parallel slave receive bits not updated at baud clock edge");

  a_master_tx_sample: assert property (
    (cu_mode == qcu_pkg::QCU_PAR_MASTER) && $fell(symbol_clock) ##1 $stable(mode_reg)
    |=> tx_sym_valid && (tx_sym.sign == $past(tx_sign_s)) && (tx_sym.mag == $past(tx_mag_s)))
    else $error("parallel master transmit symbol not taken after symbol clock fall");

  a_serial_rx_on_rise: assert property (
    is_serial(cu_mode) && $stable(mode_reg) && $changed(rx_sign_out) |-> $rose(bit_clock))
    else $error("serial receive data changed away from a bit clock rise");

  a_bit_clock_framed: assert property (
    $rose(symbol_clock) |-> $rose(bit_clock) ##1 !$rose(bit_clock))
    else $error("bit clock not aligned to symbol clock");

  a_serial_first_bit: assert property (
    (cu_mode == qcu_pkg::QCU_SER_SIGN_FIRST) && ev_sym_rise && $stable(mode_reg)
    |=> (rx_sign_out == $past(rx_sym_in.sign)) ##0 (rx_second == $past(rx_sym_in.mag)))
    else $error("serial symbol first bit out of order");

  a_serial_tx_fall: assert property (
    is_serial(cu_mode) && tx_sym_valid && $stable(mode_reg) |-> $past(ev_bit_fall_b, 3))
    else $error("serial transmit symbol not closed by a bit clock fall");

  c_master_symbol: cover property ((cu_mode == qcu_pkg::QCU_PAR_MASTER) && tx_sym_valid);
  c_slave_symbol: cover property ((cu_mode == qcu_pkg::QCU_PAR_SLAVE) && tx_sym_valid);
  c_serial_mag: cover property ((cu_mode == qcu_pkg::QCU_SER_MAG_FIRST) && tx_sym_valid);
  c_serial_sign: cover property ((cu_mode == qcu_pkg::QCU_SER_SIGN_FIRST) && tx_sym_valid);

endmodule

`default_nettype wire

// ==== qcu_params.svh ====
// register map, field positions, reset values and timing counts of the channel unit interface
`ifndef QCU_PARAMS_SVH
`define QCU_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define QCU_ADDR_MODE 8'h06
`define QCU_ADDR_STATUS 8'h07

// ----------------------------------------------------------------
// mode register fields and reset
// ----------------------------------------------------------------
`define QCU_FLD_MODE_LSB 0
`define QCU_FLD_RXEDGE 2
`define QCU_FLD_TXEDGE 3
`define QCU_MODE_RESET 8'h00

// ----------------------------------------------------------------
// timing: system clock cycles per symbol (multiple of 4)
// ----------------------------------------------------------------
`define QCU_SYM_CYCLES 8

`endif

// ==== qcu_pkg.sv ====
// types shared by the channel unit interface modules
`default_nettype none

package qcu_pkg;

  // ----------------------------------------------------------------
  // interface modes, in register code order
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    QCU_PAR_MASTER,
    QCU_PAR_SLAVE,
    QCU_SER_MAG_FIRST,
    QCU_SER_SIGN_FIRST
  } qcu_mode_t;

  // ----------------------------------------------------------------
  // one quaternary symbol
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sign;
    logic mag;
  } qcu_sym_t;

endpackage

`default_nettype wire

// ==== qcu_sync.sv ====
// two flip-flop synchroniser for a group of pin inputs
`default_nettype none

module qcu_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // asynchronous inputs and synchronised outputs
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_q;

  always_comb begin
    next_stage1 = d;
    next_q = stage1;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stage1 <= '0;
      q <= '0;
    end else begin
      stage1 <= next_stage1;
      q <= next_q;
    end
  end

endmodule

`default_nettype wire

// ==== qcu_clkgen.sv ====
// symbol clock and bit clock divider with edge strobes
`default_nettype none

module qcu_clkgen #(
  parameter int SYM_CYCLES = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // clocks driven out
  output logic symbol_clock,
  output logic bit_clock,
  // strobes, high in the cycle before the matching edge appears
  output logic ev_sym_rise,
  output logic ev_sym_fall,
  output logic ev_bit_fall_a,
  output logic ev_bit_fall_b
);

  localparam int CW = $clog2(SYM_CYCLES);
  localparam logic [CW-1:0] LAST = CW'(SYM_CYCLES - 1);
  localparam logic [CW-1:0] HALF = CW'(SYM_CYCLES / 2);
  localparam logic [CW-1:0] QUART = CW'(SYM_CYCLES / 4);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_symbol_clock;
  logic next_bit_clock;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  always_comb begin
    next_cnt = (cnt == LAST) ? '0 : cnt + CW'(1);
    next_symbol_clock = next_cnt < HALF;
    next_bit_clock = (next_cnt < QUART) || ((next_cnt >= HALF) && (next_cnt < HALF + QUART));
    ev_sym_rise = next_cnt == '0;
    ev_sym_fall = next_cnt == HALF;
    ev_bit_fall_a = next_cnt == QUART;
    ev_bit_fall_b = next_cnt == HALF + QUART;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt <= LAST;
      symbol_clock <= 1'b0;
      bit_clock <= 1'b0;
    end else begin
      cnt <= next_cnt;
      symbol_clock <= next_symbol_clock;
      bit_clock <= next_bit_clock;
    end
  end

endmodule

`default_nettype wire

// ==== qcu_framer_model.sv ====
// behavioural channel unit framer facing the symbol interface
`default_nettype none

module qcu_framer_model (
  // device clocks and receive pins
  input wire logic symbol_clock,
  input wire logic rx_sign_out,
  input wire logic rx_magnitude_out,
  // configuration mirrored by the bench
  input wire qcu_pkg::qcu_mode_t mode,
  input wire logic tx_edge_fall,
  // pins toward the device
  output logic tx_sign_in,
  output logic tx_magnitude_in,
  output logic tx_baud_clock_in,
  output logic rx_baud_clock_in,
  // symbol the device should take and symbol it sent
  output qcu_pkg::qcu_sym_t exp_tx,
  output qcu_pkg::qcu_sym_t rx_seen
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] cnt = 2'h0;
  logic baud = 1'b0;
  logic first_bit = 1'b0;
  logic bit1 = 1'b0;
  logic slave;
  logic serial;
  logic mag_first;

  assign slave = (mode == qcu_pkg::QCU_PAR_SLAVE);
  assign serial = mode[1];
  assign mag_first = (mode == qcu_pkg::QCU_SER_MAG_FIRST);
  // baud clocks share the 64 ns symbol period, held low outside slave mode
  assign tx_baud_clock_in = slave & baud;
  assign rx_baud_clock_in = slave & ~baud;

  initial begin
    tx_sign_in = 1'b0;
    tx_magnitude_in = 1'b0;
    exp_tx = qcu_pkg::qcu_sym_t'(2'h0);
    rx_seen = qcu_pkg::qcu_sym_t'(2'h0);
  end

  always begin
    #32;
    baud = ~baud;
  end

  task automatic present();
    cnt = cnt + 2'h1;
    tx_sign_in = cnt[1];
    tx_magnitude_in = cnt[0];
  endtask

  // ----------------------------------------------------------------
  // parallel: change away from the sampling edge, hold across it
  // ----------------------------------------------------------------
  always @(posedge symbol_clock) begin
    if (mode == qcu_pkg::QCU_PAR_MASTER) begin
      #1;
      present();
    end
  end

  always @(negedge symbol_clock) begin
    if (mode == qcu_pkg::QCU_PAR_MASTER) begin
      exp_tx = qcu_pkg::qcu_sym_t'(cnt);
    end
  end

  always @(tx_baud_clock_in) begin
    if (slave && tx_baud_clock_in === tx_edge_fall) begin
      #1;
      present();
    end else if (slave) begin
      exp_tx = qcu_pkg::qcu_sym_t'(cnt);
    end
  end

  // ----------------------------------------------------------------
  // serial: bits change after bit clock rises; transmit bits are taken at its falls, receive bits 1 ns after its rises
  // ----------------------------------------------------------------
  always @(posedge rx_magnitude_out) begin
    if (serial) begin
      #1;
      first_bit = symbol_clock;
      if (first_bit) begin
        cnt = cnt + 2'h1;
        bit1 = rx_sign_out;
      end else begin
        rx_seen = qcu_pkg::qcu_sym_t'(mag_first ? {rx_sign_out, bit1} : {bit1, rx_sign_out});
      end
      tx_sign_in = (first_bit == mag_first) ? cnt[0] : cnt[1];
      tx_magnitude_in = 1'b1;
    end
  end

  always @(negedge rx_magnitude_out) begin
    if (serial && !symbol_clock) begin
      exp_tx = qcu_pkg::qcu_sym_t'(cnt);
    end
  end
endmodule

`default_nettype wire

// ==== quat_channel_unit_interface_tb.sv ====
// self-checking bench of the channel unit symbol interface
`include "qcu_params.svh"
`default_nettype none

module quat_channel_unit_interface_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int SYM = 8;

  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic symbol_clock;
  logic rx_sign_out;
  logic rx_magnitude_out;
  logic tx_sign_in;
  logic tx_magnitude_in;
  logic tx_baud_clock_in;
  logic rx_baud_clock_in;
  qcu_pkg::qcu_sym_t rx_sym_in = qcu_pkg::qcu_sym_t'(2'h0);
  qcu_pkg::qcu_sym_t tx_sym;
  logic tx_sym_valid;
  qcu_pkg::qcu_mode_t mode_tb = qcu_pkg::QCU_PAR_MASTER;
  logic tx_edge_fall = 1'b0;
  qcu_pkg::qcu_sym_t exp_tx;
  qcu_pkg::qcu_sym_t rx_seen;
  int err_total = 0;
  int comparisons = 0;
  int waited = 0;
  logic [7:0] d;

  always #4 clk_sys = ~clk_sys;

  qcu_top #(.SYM_CYCLES(SYM)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .symbol_clock(symbol_clock), .rx_sign_out(rx_sign_out), .rx_magnitude_out(rx_magnitude_out),
    .tx_sign_in(tx_sign_in), .tx_magnitude_in(tx_magnitude_in), .tx_baud_clock_in(tx_baud_clock_in),
    .rx_baud_clock_in(rx_baud_clock_in), .rx_sym_in(rx_sym_in), .tx_sym(tx_sym), .tx_sym_valid(tx_sym_valid)
  );

  qcu_framer_model i_framer (
    .symbol_clock(symbol_clock), .rx_sign_out(rx_sign_out), .rx_magnitude_out(rx_magnitude_out),
    .mode(mode_tb), .tx_edge_fall(tx_edge_fall), .tx_sign_in(tx_sign_in), .tx_magnitude_in(tx_magnitude_in),
    .tx_baud_clock_in(tx_baud_clock_in), .rx_baud_clock_in(rx_baud_clock_in), .exp_tx(exp_tx), .rx_seen(rx_seen)
  );

  // ----------------------------------------------------------------
  // checking, waiting and register access
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (err_total == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, want, seen);
    end
  endtask

  // k 0 watches the symbol clock, k 1 the transmit strobe
  task automatic wait_until(input int k, input logic lvl);
    int n;
    n = 0;
    while (((k == 0) ? symbol_clock : tx_sym_valid) !== lvl) begin
      @(negedge clk_sys);
      n++;
      if (n > 4 * SYM) begin
        err_total++;
        print_verdict();
      end
    end
    waited = n;
  endtask

  task automatic wait_edge(input logic lvl);
    wait_until(0, !lvl);
    wait_until(0, lvl);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    v = rdata;
  endtask

  // ----------------------------------------------------------------
  // mode scenarios
  // ----------------------------------------------------------------
  task automatic set_mode(input logic [1:0] m, input logic e);
    reg_wr(`QCU_ADDR_MODE, {4'h0, e, e, m});
    mode_tb <= qcu_pkg::qcu_mode_t'(m);
    tx_edge_fall <= e;
    repeat (3) wait_edge(1'b1);
  endtask

  // receive symbol changes mid-symbol; master must show it at the very next rise
  task automatic rx_run();
    for (int v = 0; v < 4; v++) begin
      wait_edge(1'b0);
      @(posedge clk_sys);
      rx_sym_in <= qcu_pkg::qcu_sym_t'(v[1:0]);
      repeat ((mode_tb == qcu_pkg::QCU_PAR_MASTER) ? 1 : 3) wait_edge(1'b1);
      if (mode_tb[1]) check("serial rx symbol", {6'h0, rx_seen}, 8'(v));
      else check("parallel rx symbol", {6'h0, rx_sign_out, rx_magnitude_out}, 8'(v));
    end
  endtask

  task automatic tx_run();
    repeat (6) begin
      wait_until(1, 1'b1);
      check("tx symbol", {6'h0, tx_sym}, {6'h0, exp_tx});
      @(negedge clk_sys);
    end
  endtask

  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    reg_rd(`QCU_ADDR_MODE, d);
    check("mode reset", d, `QCU_MODE_RESET);
    reg_wr(`QCU_ADDR_MODE, 8'hF0);
    reg_rd(`QCU_ADDR_MODE, d);
    check("mode readback", d, 8'hF0);
    reg_wr(`QCU_ADDR_STATUS, 8'hFF);
    reg_rd(`QCU_ADDR_STATUS, d);
    check("status spare bits", d & 8'hE0, 8'h00);
    reg_rd(8'h3C, d);
    check("unmapped read", d, 8'h00);
    wait_edge(1'b1);
    wait_until(0, 1'b0);
    d = 8'(waited);
    wait_until(0, 1'b1);
    check("symbol period", d + 8'(waited), 8'(SYM));
    for (int m = 0; m < 4; m++) begin
      for (int e = 0; e < 2; e++) begin
        set_mode(2'(m), e[0]);
        rx_run();
        tx_run();
        reg_rd(`QCU_ADDR_STATUS, d);
        check("status last tx symbol", d & 8'hE3, {6'h0, exp_tx});
      end
    end
    print_verdict();
  end
endmodule

`default_nettype wire
